// ---- include/can_filt_pkg.sv ----
// constants for the can receive acceptance filter and routing block
package can_filt_pkg;
	localparam int          NUM_FLT     = 16;
	localparam int          NUM_MSK     = 3;
	localparam int          ROUTE_REGS  = 4;
	localparam int          MSEL_REGS   = 2;
	localparam int          ADDR_W      = 8;
	localparam int          ROUTE_W     = 4;
	localparam int          MSEL_W      = 2;
	localparam int          SID_W       = 11;
	localparam int          EID_W       = 18;
	localparam int          CNT_W       = 8;

	// byte offsets on the register bus
	localparam logic [7:0]  OFS_ROUTE   = 8'h00;
	localparam logic [7:0]  OFS_MSEL    = 8'h10;
	localparam logic [7:0]  OFS_FEN     = 8'h18;
	localparam logic [7:0]  OFS_STAT    = 8'h1C;
	localparam logic [7:0]  OFS_MASK    = 8'h20;
	localparam logic [7:0]  OFS_MASK_END = 8'h38;
	localparam logic [7:0]  OFS_FLT     = 8'h40;
	localparam logic [7:0]  OFS_FLT_END = 8'hC0;

	// field positions in the identifier registers
	localparam int          SID_LSB     = 5;
	localparam int          SID_MSB     = 15;
	localparam int          QUAL_BIT    = 3;
	localparam int          EIDH_MSB    = 1;
	localparam logic [15:0] SID_IMPL    = 16'hFFEB;

	// field positions in the status register
	localparam int          ST_DEST_LSB = 0;
	localparam int          ST_FLT_LSB  = 4;
	localparam int          ST_HIT_BIT  = 8;
	localparam int          ST_ACC_LSB  = 16;
	localparam int          ST_REJ_LSB  = 24;

	// codes and reset values
	localparam logic [3:0]  ROUTE_FIFO  = 4'hF;
	localparam logic [1:0]  MSEL_NONE   = 2'h3;
	localparam logic [15:0] ROUTE_RST   = 16'h0000;
	localparam logic [15:0] MSEL_RST    = 16'h0000;
	localparam logic [15:0] FEN_RST     = 16'hFFFF;
endpackage

// ---- verilog/filter_match.sv ----
// identifier comparison of one acceptance filter against a received frame
module filter_match (
	input  wire logic [15:0]                      flt_sid,
	input  wire logic [15:0]                      flt_eid,
	input  wire logic [15:0]                      msk_sid,
	input  wire logic [15:0]                      msk_eid,
	input  wire logic                             enable,
	input  wire logic                             rx_ide,
	input  wire logic [can_filt_pkg::SID_W-1:0]   rx_sid,
	input  wire logic [can_filt_pkg::EID_W-1:0]   rx_eid,
	output logic                                  hit
);
	import can_filt_pkg::*;

	logic [SID_W-1:0] sid_diff;
	logic [EID_W-1:0] eid_diff;
	logic             sid_ok;
	logic             eid_ok;
	logic             type_ok;

	// mask bit 1 compares, 0 is a don't-care
	assign sid_diff = (flt_sid[SID_MSB:SID_LSB] ^ rx_sid) & msk_sid[SID_MSB:SID_LSB];
	assign eid_diff = ({flt_sid[EIDH_MSB:0], flt_eid} ^ rx_eid)
		& {msk_sid[EIDH_MSB:0], msk_eid};
	assign sid_ok   = (sid_diff == '0);
	assign eid_ok   = (eid_diff == '0);
	// qualifier only counts when the mask asks for a type check
	assign type_ok  = ~msk_sid[QUAL_BIT] | (flt_sid[QUAL_BIT] == rx_ide);
	// standard frames carry no extended bits to compare
	assign hit      = enable & sid_ok & (eid_ok | ~rx_ide) & type_ok;
endmodule

// ---- verilog/first_hit_pick.sv ----
// picks the lowest-numbered set bit of a hit vector
module first_hit_pick #(
	parameter int N = 16
) (
	input  wire logic [N-1:0]         hits,
	output logic                      any,
	output logic [$clog2(N)-1:0]      idx
);
	if (N < 2) begin : g_chk
		$error("first_hit_pick needs at least two inputs");
	end

	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (hits[i]) begin
				any = 1'b1;
				idx = i[$clog2(N)-1:0];
			end
		end
	end
endmodule

// ---- verilog/can_rx_filter.sv ----
// can receive acceptance filters with routing to rx buffers or the rx fifo
// What this block does
// - route field value k from 0 to 14 stores the filter's hits in buffer k.
// - route field value 1111 stores the filter's hits in the receive fifo.
// - route fields sit four per register, lowest filter in bits 3-0.
// - each compared standard id bit must equal the stored bit in bits 15-5.
// - extended bits 17-16 sit in bits 1-0, bits 15-0 in second register.
// - qualifier bit 3 picks extended or standard frames when type check is on.
// - mask choice 00, 01, 10 picks mask set 0, 1, 2; 11 means no mask.
// - mask choice fields are two bits per filter, filter 0 in bits 1-0.
// - bits 4 and 2 of the standard id register read zero, ignore writes.
// - routing and mask choice clear on reset; identifier bits stay unknown.
// - a mask bit of 1 compares that id bit, 0 makes it a don't-care.
// - with type check clear both frame kinds pass on identifier match.
// - only filters whose enable bit is set can accept a frame.
module can_rx_filter (
	input  wire logic                              core_clk,
	input  wire logic                              resetn,
	input  wire logic                              ce,
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [can_filt_pkg::ADDR_W-1:0]   wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [31:0]                       wb_dat_i,
	output logic [31:0]                            wb_dat_o,
	output logic                                   wb_ack_o,
	input  wire logic                              rx_valid,
	input  wire logic                              rx_ide,
	input  wire logic [can_filt_pkg::SID_W-1:0]    rx_sid,
	input  wire logic [can_filt_pkg::EID_W-1:0]    rx_eid,
	output logic                                   acc_valid,
	output logic                                   acc_fifo,
	output logic [can_filt_pkg::ROUTE_W-1:0]       acc_buf,
	output logic [3:0]                             acc_filter,
	output logic                                   rej_valid
);
	import can_filt_pkg::*;

	// register storage
	logic [15:0]        route_q [ROUTE_REGS];
	logic [15:0]        msel_q [MSEL_REGS];
	logic [15:0]        fen_q;
	logic [15:0]        flt_sid_q [NUM_FLT];
	logic [15:0]        flt_eid_q [NUM_FLT];
	logic [15:0]        msk_sid_q [NUM_MSK];
	logic [15:0]        msk_eid_q [NUM_MSK];

	// bus side
	logic               ack_q;
	logic [31:0]        dat_q;
	logic [31:0]        rd_d;
	logic               req;
	logic               wr_en;
	logic               is_route;
	logic               is_msel;
	logic               is_fen;
	logic               is_stat;
	logic               is_mask;
	logic               is_flt;
	logic [7:0]         mask_off;
	logic [7:0]         flt_off;
	logic [1:0]         route_idx;
	logic               msel_idx;
	logic [1:0]         mask_set;
	logic               mask_ext;
	logic [3:0]         flt_idx;
	logic               flt_ext;

	// match side
	logic [NUM_FLT-1:0] hits;
	logic [ROUTE_W-1:0] route_f [NUM_FLT];
	logic               first_any;
	logic [3:0]         first_idx;
	logic [ROUTE_W-1:0] first_dest;

	// result and status
	logic               acc_valid_q;
	logic               rej_valid_q;
	logic               acc_fifo_q;
	logic [ROUTE_W-1:0] acc_buf_q;
	logic [3:0]         acc_filter_q;
	logic               last_hit_q;
	logic [CNT_W-1:0]   acc_cnt_q;
	logic [CNT_W-1:0]   rej_cnt_q;
	logic               stat_clr;

	function automatic logic [15:0] wr16(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel
	);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			r[15:8] = dat[15:8];
		end
		return r;
	endfunction

	// address decode
	assign req       = wb_cyc_i & wb_stb_i;
	assign wr_en     = req & wb_we_i & ack_q;
	assign mask_off  = wb_adr_i - OFS_MASK;
	assign flt_off   = wb_adr_i - OFS_FLT;
	assign route_idx = wb_adr_i[3:2];
	assign msel_idx  = wb_adr_i[2];
	assign mask_set  = mask_off[4:3];
	assign mask_ext  = mask_off[2];
	assign flt_idx   = flt_off[6:3];
	assign flt_ext   = flt_off[2];
	assign is_route  = (wb_adr_i < OFS_MSEL);
	assign is_msel   = (wb_adr_i[7:3] == OFS_MSEL[7:3]);
	assign is_fen    = (wb_adr_i[7:2] == OFS_FEN[7:2]);
	assign is_stat   = (wb_adr_i[7:2] == OFS_STAT[7:2]);
	assign is_mask   = (wb_adr_i >= OFS_MASK) && (wb_adr_i < OFS_MASK_END);
	assign is_flt    = (wb_adr_i >= OFS_FLT) && (wb_adr_i < OFS_FLT_END);
	assign stat_clr  = wr_en & is_stat;

	// one-cycle ack, dropped the cycle after it is given
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= req & ~ack_q;
		end
	end

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_d = '0;
		if (is_route) begin
			rd_d[15:0] = route_q[route_idx];
		end else if (is_msel) begin
			rd_d[15:0] = msel_q[msel_idx];
		end else if (is_fen) begin
			rd_d[15:0] = fen_q;
		end else if (is_stat) begin
			rd_d[ST_DEST_LSB +: ROUTE_W] = acc_buf_q;
			rd_d[ST_FLT_LSB +: 4]        = acc_filter_q;
			rd_d[ST_HIT_BIT]             = last_hit_q;
			rd_d[ST_ACC_LSB +: CNT_W]    = acc_cnt_q;
			rd_d[ST_REJ_LSB +: CNT_W]    = rej_cnt_q;
		end else if (is_mask && mask_set != 2'h3) begin
			rd_d[15:0] = mask_ext ? msk_eid_q[mask_set] : msk_sid_q[mask_set];
		end else if (is_flt) begin
			rd_d[15:0] = flt_ext ? flt_eid_q[flt_idx] : flt_sid_q[flt_idx];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			dat_q <= '0;
		end else if (ce) begin
			if (req & ~ack_q & ~wb_we_i) begin
				dat_q <= rd_d;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// routing fields, four filters per register
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int r = 0; r < ROUTE_REGS; r++) begin
				route_q[r] <= ROUTE_RST;
			end
		end else if (ce) begin
			if (wr_en & is_route) begin
				route_q[route_idx] <= wr16(route_q[route_idx], wb_dat_i, wb_sel_i);
			end
		end
	end

	// mask choice fields, eight filters per register
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int r = 0; r < MSEL_REGS; r++) begin
				msel_q[r] <= MSEL_RST;
			end
		end else if (ce) begin
			if (wr_en & is_msel) begin
				msel_q[msel_idx] <= wr16(msel_q[msel_idx], wb_dat_i, wb_sel_i);
			end
		end
	end

	// filter enables, all filters on after reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fen_q <= FEN_RST;
		end else if (ce) begin
			if (wr_en & is_fen) begin
				fen_q <= wr16(fen_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// filter identifiers hold no reset value
	always_ff @(posedge core_clk) begin
		if (ce && wr_en && is_flt) begin
			if (flt_ext) begin
				flt_eid_q[flt_idx] <= wr16(flt_eid_q[flt_idx], wb_dat_i, wb_sel_i);
			end else begin
				flt_sid_q[flt_idx] <= wr16(flt_sid_q[flt_idx], wb_dat_i, wb_sel_i)
					& SID_IMPL;
			end
		end
	end

	// mask sets, unimplemented bits held at zero
	always_ff @(posedge core_clk) begin
		if (ce && wr_en && is_mask && mask_set != 2'h3) begin
			if (mask_ext) begin
				msk_eid_q[mask_set] <= wr16(msk_eid_q[mask_set], wb_dat_i, wb_sel_i);
			end else begin
				msk_sid_q[mask_set] <= wr16(msk_sid_q[mask_set], wb_dat_i, wb_sel_i)
					& SID_IMPL;
			end
		end
	end

	// per-filter compare
	for (genvar i = 0; i < NUM_FLT; i++) begin : g_flt
		logic [MSEL_W-1:0] choice;
		logic [15:0]       m_sid;
		logic [15:0]       m_eid;

		assign choice     = msel_q[i / 8][(i % 8) * MSEL_W +: MSEL_W];
		assign route_f[i] = route_q[i / 4][(i % 4) * ROUTE_W +: ROUTE_W];

		// no mask compares every bit and the frame type
		always_comb begin
			m_sid = SID_IMPL;
			m_eid = 16'hFFFF;
			unique case (choice)
				2'h0: begin
					m_sid = msk_sid_q[0];
					m_eid = msk_eid_q[0];
				end
				2'h1: begin
					m_sid = msk_sid_q[1];
					m_eid = msk_eid_q[1];
				end
				2'h2: begin
					m_sid = msk_sid_q[2];
					m_eid = msk_eid_q[2];
				end
				MSEL_NONE: begin
					m_sid = SID_IMPL;
					m_eid = 16'hFFFF;
				end
			endcase
		end

		filter_match u_match (
			.flt_sid (flt_sid_q[i]),
			.flt_eid (flt_eid_q[i]),
			.msk_sid (m_sid),
			.msk_eid (m_eid),
			.enable  (fen_q[i]),
			.rx_ide  (rx_ide),
			.rx_sid  (rx_sid),
			.rx_eid  (rx_eid),
			.hit     (hits[i])
		);
	end

	first_hit_pick #(
		.N (NUM_FLT)
	) u_pick (
		.hits (hits),
		.any  (first_any),
		.idx  (first_idx)
	);

	assign first_dest = route_f[first_idx];

	// result pulses, one cycle after the frame strobe
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_valid_q <= 1'b0;
			rej_valid_q <= 1'b0;
		end else if (ce) begin
			acc_valid_q <= rx_valid & first_any;
			rej_valid_q <= rx_valid & ~first_any;
		end
	end

	// destination of the last accepted frame
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_fifo_q   <= 1'b0;
			acc_buf_q    <= '0;
			acc_filter_q <= '0;
		end else if (ce) begin
			if (rx_valid & first_any) begin
				acc_fifo_q   <= (first_dest == ROUTE_FIFO);
				acc_buf_q    <= first_dest;
				acc_filter_q <= first_idx;
			end
		end
	end

	// last-frame flag follows every frame
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			last_hit_q <= 1'b0;
		end else if (ce) begin
			if (rx_valid) begin
				last_hit_q <= first_any;
			end
		end
	end

	// counters cleared by a status write; a frame in the same cycle still counts
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc_cnt_q <= '0;
			rej_cnt_q <= '0;
		end else if (ce) begin
			if (rx_valid & first_any) begin
				acc_cnt_q <= stat_clr ? CNT_W'(1) : acc_cnt_q + CNT_W'(1);
			end else if (stat_clr) begin
				acc_cnt_q <= '0;
			end
			if (rx_valid & ~first_any) begin
				rej_cnt_q <= stat_clr ? CNT_W'(1) : rej_cnt_q + CNT_W'(1);
			end else if (stat_clr) begin
				rej_cnt_q <= '0;
			end
		end
	end

	assign acc_valid  = acc_valid_q;
	assign rej_valid  = rej_valid_q;
	assign acc_fifo   = acc_fifo_q;
	assign acc_buf    = acc_buf_q;
	assign acc_filter = acc_filter_q;
endmodule

// ---- verification/rx_filter_checker.sv ----
// port assertions for the can receive filter
module rx_filter_checker import can_filt_pkg::*; (
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic              ce,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              rx_valid,
	input wire logic              acc_valid,
	input wire logic              acc_fifo,
	input wire logic [3:0]        acc_buf,
	input wire logic [3:0]        acc_filter,
	input wire logic              rej_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic rq;
	assign rq = wb_cyc_i && wb_stb_i && !wb_ack_o && ce && !wb_we_i;
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack too long");
	a_frame_answer: assert property (rx_valid && ce |=> acc_valid != rej_valid)
		else $error("no single frame answer");
	a_no_spurious: assert property (!rx_valid && ce |=> !acc_valid && !rej_valid)
		else $error("answer without frame");
	a_ce_freeze: assert property (!ce |=> $stable({wb_ack_o, wb_dat_o, acc_valid, rej_valid,
		acc_fifo, acc_buf, acc_filter})) else $error("state moved while frozen");
	a_fifo_route: assert property (acc_valid |-> acc_fifo == (acc_buf == ROUTE_FIFO))
		else $error("fifo flag wrong");
	a_route_hold: assert property (!acc_valid |-> $stable({acc_fifo, acc_buf, acc_filter}))
		else $error("route moved");
	a_unmapped_zero: assert property (rq && wb_adr_i >= OFS_FLT_END |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_sid_reserved: assert property (rq && wb_adr_i >= OFS_FLT && wb_adr_i < OFS_FLT_END
		&& !wb_adr_i[2] |=> !wb_dat_o[4] && !wb_dat_o[2]) else $error("reserved bit set");
	a_upper_zero: assert property (rq && wb_adr_i[7:2] != 6'h07 |=> wb_dat_o[31:16] == 16'h0)
		else $error("upper half set");
	c_fifo: cover property (acc_valid && acc_fifo);
	c_reject: cover property (rej_valid);
	c_back: cover property (rx_valid ##1 rx_valid);
	c_frozen: cover property (!ce && rx_valid);
endmodule

bind can_rx_filter rx_filter_checker i_chk (.core_clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_valid, .acc_valid, .acc_fifo, .acc_buf,
	.acc_filter, .rej_valid);

// ---- verification/can_frame_source.sv ----
// protocol engine model handing received frame ids to the filter
module can_frame_source import can_filt_pkg::*; (
	input  wire logic        core_clk,
	output logic             rx_valid,
	output logic             rx_ide,
	output logic [SID_W-1:0] rx_sid,
	output logic [EID_W-1:0] rx_eid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid = 1'b0;
		rx_ide = 1'b0;
		rx_sid = 11'h2AA;
		rx_eid = 18'h15555;
	end
	// ids scrambled once the pulse ends; keep lets the next frame follow at once
	task automatic send(input logic ide, input logic [SID_W-1:0] sid,
		input logic [EID_W-1:0] eid, input bit keep);
		rx_valid <= 1'b1;
		rx_ide <= ide;
		rx_sid <= sid;
		rx_eid <= eid;
		@(posedge core_clk);
		if (!keep) begin
			rx_valid <= 1'b0;
			rx_ide <= ~ide;
			rx_sid <= ~sid;
			rx_eid <= ~eid;
		end
	endtask
endmodule

// ---- verification/tb_top.sv ----
// testbench for the can receive filter: registers and frame routing
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import can_filt_pkg::*;
	logic              core_clk, resetn, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [3:0]        wb_sel_i, acc_buf, acc_filter;
	logic [31:0]       wb_dat_i, wb_dat_o, rd;
	logic              rx_valid, rx_ide, acc_valid, acc_fifo, rej_valid;
	logic [SID_W-1:0]  rx_sid;
	logic [EID_W-1:0]  rx_eid;
	logic [15:0]       mtab [6] = '{16'hFFE0, 16'h0, 16'hFFEB, 16'hFFFF, 16'h0, 16'h0};
	int                fails, tests_run;

	can_rx_filter i_can_rx_filter (.core_clk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_valid, .rx_ide, .rx_sid,
		.rx_eid, .acc_valid, .acc_fifo, .acc_buf, .acc_filter, .rej_valid);
	can_frame_source i_can_frame_source (.core_clk, .rx_valid, .rx_ide, .rx_sid, .rx_eid);

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// waits for ack as long as it takes; only the watchdog ends a hung request
	task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s = 4'h3);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {16'h0, d};
		do begin
			@(posedge core_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0);
		check("register", rd, {16'h0, e});
	endtask

	// f is the winning filter, negative when no filter may accept
	task automatic frm(input logic ide, input logic [10:0] sid, input logic [17:0] eid, int f);
		@(posedge core_clk);
		i_can_frame_source.send(ide, sid, eid, 1'b0);
		#1;
		if (f < 0)
			check("reject", {acc_valid, rej_valid}, 2'b01);
		else
			check("accept", {acc_valid, rej_valid, acc_fifo, acc_buf, acc_filter},
				{2'b10, f == 0, 4'(15 - f), 4'(f)});
	endtask

	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		fails = 0;
		tests_run = 0;
		resetn = 1'b0;
		ce = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		for (int k = 0; k < 8; k++)
			rchk(8'(4 * k), k == 6 ? 16'hFFFF : 16'h0000);
		bus(1'b1, OFS_FEN, 16'h0000);
		for (int i = 0; i < 6; i++)
			bus(1'b1, 8'(OFS_MASK + 4 * i), mtab[i]);
		bus(1'b1, OFS_FLT, 16'hFFFF);
		rchk(OFS_FLT, 16'hFFEB);
		for (int n = 0; n < 16; n++) begin
			bus(1'b1, 8'(OFS_FLT + 8 * n), {11'(16'h100 + n), 5'(n == 5 ? 8 : 0)});
			bus(1'b1, 8'(OFS_FLT + 8 * n + 4), 16'h1234);
		end
		for (int k = 0; k < 4; k++)
			bus(1'b1, 8'(4 * k), {4'(12 - 4 * k), 4'(13 - 4 * k), 4'(14 - 4 * k), 4'(15 - 4 * k)});
		rchk(8'h0C, 16'h0123);
		rchk(8'h4C, 16'h1234);
		bus(1'b1, 8'hC0, 16'h5A5A);
		rchk(8'hC0, 16'h0000);
		bus(1'b1, OFS_FEN, 16'hFFFF);
		for (int n = 0; n < 16; n++)
			frm(1'b0, 11'(16'h100 + n), 18'h0, n);
		bus(1'b1, OFS_MSEL, 16'h0400);
		frm(1'b0, 11'h105, 18'h0, -1);
		frm(1'b1, 11'h105, 18'h01234, 5);
		frm(1'b1, 11'h105, 18'h01235, -1);
		frm(1'b1, 11'h103, 18'h3FFFF, 3);
		bus(1'b1, OFS_MSEL, 16'h0800);
		frm(1'b1, 11'h7FF, 18'h0, 5);
		frm(1'b0, 11'h102, 18'h0, 2);
		bus(1'b1, OFS_MSEL, 16'h0C00);
		frm(1'b1, 11'h105, 18'h01234, 5);
		frm(1'b1, 11'h105, 18'h21234, -1);
		bus(1'b1, 8'(OFS_MSEL + 4), 16'h8000);
		rchk(OFS_MSEL, 16'h0C00);
		frm(1'b0, 11'h7FF, 18'h0, 15);
		bus(1'b1, OFS_FEN, 16'h7FF7);
		frm(1'b0, 11'h103, 18'h0, -1);
		// a frame while the clock enable is low must leave no answer and no count
		@(posedge core_clk);
		ce <= 1'b0;
		i_can_frame_source.send(1'b0, 11'h104, 18'h0, 1'b0);
		#1;
		check("frozen", {acc_valid, rej_valid}, 2'b00);
		@(posedge core_clk);
		ce <= 1'b1;
		@(posedge core_clk);
		i_can_frame_source.send(1'b0, 11'h101, 18'h0, 1'b1);
		i_can_frame_source.send(1'b0, 11'h104, 18'h0, 1'b0);
		#1;
		check("second frame", {acc_valid, acc_buf, acc_filter}, 9'h1B4);
		// 24 accepted, 4 rejected, last winner filter 4 routed to buffer 11
		bus(1'b0, OFS_STAT, 16'h0);
		check("status", rd, 32'h0418014B);
		bus(1'b1, OFS_STAT, 16'h0);
		bus(1'b0, OFS_STAT, 16'h0);
		check("status cleared", rd, 32'h0000014B);
		// second reset in mid-run clears routing and mask choice again
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rchk(8'h0C, 16'h0000);
		rchk(OFS_MSEL, 16'h0000);
		rchk(OFS_FEN, 16'hFFFF);
		bus(1'b1, OFS_FEN, 16'h0000, 4'h2);
		rchk(OFS_FEN, 16'h00FF);
		tally_and_finish();
	end
endmodule
